// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import tpi_pkg::*;
  logic         clk_sys, rstn, reg_wr, reg_rd, timer_run, accum_run, div64_tick, accum_event;
  logic         clk_en, accum_gate_tick, accum_gate_end;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, oc_enable, oc_level, ext_lvl, pin_in, pin_out, pin_oe_n;
  tpi_mode_type mode;
  tpi_chan_type chan;
  int           n_errors = 0, checks_done = 0, cyc = 0, n_t, n_e, n_g, n_d;

  tpi_port_io i_tpi_port_io (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode),
    .oc_enable(oc_enable), .oc_level(oc_level), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .chan(chan), .timer_run(timer_run), .accum_run(accum_run),
    .div64_tick(div64_tick), .accum_event(accum_event), .accum_gate_tick(accum_gate_tick),
    .accum_gate_end(accum_gate_end));
  tpi_pin_model i_tpi_pin_model (.clk_sys(clk_sys), .ext_lvl(ext_lvl), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic count(input int n);
    n_t = 0;
    n_e = 0;
    n_g = 0;
    n_d = 0;
    repeat (n) begin
      settle(1);
      n_t += div64_tick;
      n_e += accum_event;
      n_g += accum_gate_tick;
      n_d += accum_gate_end;
    end
  endtask

  task automatic t_port;
    chk(pin_oe_n, 8'hFF);
    rd(TPI_ADDR_DIRECTION, 8'h00);
    rd(8'hC0, 8'h00);
    ext_lvl <= 8'h3C;
    wr(TPI_ADDR_DATA, 8'hA5);
    wr(TPI_ADDR_DIRECTION, 8'h0F);
    settle(6);
    chk(pin_oe_n, 8'hF0);
    chk(pin_out & 8'h0F, 8'h05);
    rd(TPI_ADDR_DATA, 8'h35);
    $display("port test done");
  endtask
  task automatic t_compare;
    wr(TPI_ADDR_DIRECTION, 8'h00);
    oc_level <= 8'h80;
    oc_enable <= 8'h81;
    wr(TPI_ADDR_DATA, 8'h01);
    settle(3);
    chk(pin_oe_n, 8'h7E);
    chk(pin_out & 8'h81, 8'h80);
    rd(TPI_ADDR_DIRECTION, 8'h00);
    rd(TPI_ADDR_DATA, 8'hBC);
    oc_enable <= 8'h00;
    settle(3);
    chk(pin_oe_n, 8'hFF);
    ext_lvl <= 8'h3D;
    settle(8);
    chk(chan.level, 8'h3D);
    $display("compare test done");
  endtask
  task automatic t_run;
    logic [7:0] cv [4] = '{8'h0F, 8'h03, 8'h02, 8'h01};
    logic [1:0] e;
    for (int k = 0; k < 4; k++) begin
      wr(TPI_ADDR_CONTROL, cv[k]);
      rd(TPI_ADDR_CONTROL, cv[k]);
      for (int m = 0; m < 8; m++) begin
        mode <= m[2:0];
        settle(3);
        e[0] = cv[k][0] & !m[2] & !(m[0] & cv[k][2]) & !(m[1] & cv[k][3]);
        e[1] = cv[k][1] & !m[2];
        chk({6'h00, accum_run, timer_run}, {6'h00, e});
      end
      rd(TPI_ADDR_STATUS, {6'h00, e});
    end
    mode <= 3'h0;
    $display("run test done");
  endtask
  task automatic t_accum;
    wr(TPI_ADDR_CONTROL, 8'h01);
    count(128);
    chk(n_t[7:0], 8'h02);
    wr(TPI_ADDR_CONTROL, 8'h12);
    settle(2);
    count(130);
    chk(n_t[7:0], 8'h00);
    ext_lvl <= 8'hBD;
    count(12);
    chk(n_e[7:0], 8'h01);
    wr(TPI_ADDR_CONTROL, 8'h10);
    ext_lvl <= 8'h3D;
    settle(6);
    ext_lvl <= 8'hBD;
    count(12);
    chk(n_e[7:0], 8'h00);
    $display("accumulator test done");
  endtask
  task automatic t_gated;
    wr(TPI_ADDR_CONTROL, 8'h23);
    settle(2);
    count(128);
    chk(n_g[7:0], 8'h02);
    ext_lvl <= 8'h3D;
    count(12);
    chk(n_d[7:0], 8'h01);
    count(128);
    chk(n_g[7:0], 8'h00);
    wr(TPI_ADDR_CONTROL, 8'h22);
    settle(2);
    ext_lvl <= 8'hBD;
    count(128);
    chk(n_t[7:0], 8'h00);
    chk(n_g[7:0], 8'h00);
    chk(n_d[7:0], 8'h00);
    $display("gated test done");
  endtask
  task automatic t_freeze;
    wr(TPI_ADDR_DIRECTION, 8'h0F);
    settle(8);
    clk_en <= 1'b0;
    wr(TPI_ADDR_DIRECTION, 8'hFF);
    settle(3);
    chk(pin_oe_n, 8'hF0);
    clk_en <= 1'b1;
    rd(TPI_ADDR_DIRECTION, 8'h0F);
    rstn <= 1'b0;
    settle(2);
    chk(pin_oe_n, 8'hFF);
    rstn <= 1'b1;
    settle(1);
    rd(TPI_ADDR_DIRECTION, 8'h00);
    chk({6'h00, accum_run, timer_run}, 8'h00);
    $display("freeze and reset test done");
  endtask

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    oc_enable = 8'h00;
    oc_level = 8'h00;
    ext_lvl = 8'h00;
    mode = 3'h0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    settle(1);
    t_port();
    t_compare();
    t_run();
    t_accum();
    t_gated();
    t_freeze();
    conclude();
  end
endmodule // tb_top

// ---- tpi_checker.sv ----
`timescale 1ns/100ps
module tpi_checker
  import tpi_pkg::*;
(
  // Clock, reset, register port
  input wire logic             clk_sys,
  input wire logic             rstn,
  input wire logic             clk_en,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  // Modes, compare, pins
  input tpi_pkg::tpi_mode_type mode,
  input wire logic [7:0]       oc_enable,
  input wire logic [7:0]       oc_level,
  input wire logic [7:0]       pin_in,
  input wire logic [7:0]       pin_out,
  input wire logic [7:0]       pin_oe_n,
  // Timer side
  input tpi_pkg::tpi_chan_type chan,
  input wire logic             timer_run,
  input wire logic             accum_run,
  input wire logic             div64_tick
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_dir_wr;
    reg_wr && clk_en && reg_addr == TPI_ADDR_DIRECTION && oc_enable == 8'h00 ##1 oc_enable == 8'h00;
  endsequence
  sequence s_pin_rise;
    !pin_in[0] ##1 pin_in[0] [*5];
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  dir_drive_a: assert property (s_dir_wr |=> pin_oe_n == ~$past(reg_wdata, 2))
    else $error("direction not applied");
  oc_force_a: assert property (1 |=> (pin_oe_n & $past(oc_enable)) == 8'h00)
    else $error("compare pin not output");
  oc_level_a: assert property (1 |=> ((pin_out ^ $past(oc_level)) & $past(oc_enable)) == 8'h00)
    else $error("compare pin level lost");
  stop_halt_a: assert property (mode.stop_mode |=> !timer_run && !accum_run)
    else $error("running in stop");
  tick_gap_a: assert property (div64_tick |=> !div64_tick [*8])
    else $error("ticks too close");
  tick_idle_a: assert property (!timer_run [*2] |=> !div64_tick)
    else $error("tick while halted");
  sync_lat_a: assert property (s_pin_rise |=> chan.level[0])
    else $error("level not synced");
  rise_pulse_a: assert property (chan.rise[0] |-> chan.level[0] ##1 !chan.rise[0])
    else $error("bad rise pulse");
endmodule // tpi_checker

bind tpi_port_io tpi_checker i_tpi_checker (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mode(mode), .oc_enable(oc_enable), .oc_level(oc_level),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .chan(chan),
  .timer_run(timer_run), .accum_run(accum_run), .div64_tick(div64_tick));

// ---- tpi_pin_model.sv ----
`timescale 1ns/100ps
module tpi_pin_model (
  // Clock
  input wire logic        clk_sys,
  // Commanded external levels
  input wire logic [7:0]  ext_lvl,
  // Design drive
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_n,
  // Resolved pin levels
  output logic [7:0]      pin_in
);
  logic [7:0] held;
  logic [1:0] age;
  initial begin
    held = 8'h00;
    age = 2'h0;
  end
  // Each change held three clocks
  always @(posedge clk_sys) begin
    if (age != 2'h0) begin
      age <= age - 2'h1;
    end else if (ext_lvl !== held) begin
      held <= ext_lvl;
      age <= 2'h2;
    end
  end
  assign pin_in = (held & pin_oe_n) | (pin_out & ~pin_oe_n);
endmodule // tpi_pin_model

// ---- tpi_pkg.sv ----
package tpi_pkg;

  // Register offsets
  localparam logic [7:0] TPI_ADDR_DATA      = 8'hAE;
  localparam logic [7:0] TPI_ADDR_DIRECTION = 8'hAF;
  localparam logic [7:0] TPI_ADDR_CONTROL   = 8'hB0;
  localparam logic [7:0] TPI_ADDR_STATUS    = 8'hB1;

  // Reset values
  localparam logic [7:0] TPI_RST_DATA      = 8'h00;
  localparam logic [7:0] TPI_RST_DIRECTION = 8'h00;
  localparam logic [7:0] TPI_RST_CONTROL   = 8'h00;

  // Control register fields
  localparam int TPI_CTL_TIMER_RUN    = 0;
  localparam int TPI_CTL_ACCUM_RUN    = 1;
  localparam int TPI_CTL_DEBUG_FREEZE = 2;
  localparam int TPI_CTL_WAIT_HALT    = 3;
  localparam int TPI_CTL_ACCUM_EDGE   = 4;
  localparam int TPI_CTL_ACCUM_GATED  = 5;

  // Status register fields
  localparam int TPI_STS_TIMER_ACTIVE = 0;
  localparam int TPI_STS_ACCUM_ACTIVE = 1;

  // Port geometry
  localparam int TPI_PINS      = 8;
  localparam int TPI_ACCUM_PIN = 7;

  // Divide-by-64 prescaler terminal count
  localparam logic [5:0] TPI_DIV64_LAST = 6'h3F;

  typedef struct packed {
    logic accum_gated;
    logic accum_edge;
    logic wait_halt_bit;
    logic debug_freeze_bit;
    logic accum_run_bit;
    logic timer_run_bit;
  } tpi_ctrl_type;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] rise;
    logic [7:0] fall;
  } tpi_chan_type;

  typedef struct packed {
    logic stop_mode;
    logic wait_mode;
    logic background_debug_state;
  } tpi_mode_type;

endpackage

// ---- tpi_port_io.sv ----
`timescale 1ns/100ps
// Contract
// R1: Data read returns pin level for inputs, driver value for outputs.
// R2: Data writes go to a latch; it drives only output pins.
// R3: Pins under output compare ignore data latch writes.
// R4: Accumulator input pulses must exceed two module clocks.
// R5: Capture input pulses must exceed two module clocks.
// R6: Direction bit 0 input, 1 output; cleared at reset; always accessible.
// R7: Enabled output compare forces pin to output; direction bit kept.
// R8: With compare disabled, direction bit rules the pin again.
// R9: Input capture never overrides the direction bit.
// R10: Stop mode halts the timer completely.
// R11: Debug mode keeps timer running unless freeze bit is set.
// R12: Wait mode keeps counters running unless wait halt bit set; here the bit halts only the timer, accumulator run is kept.
// R13: Timer runs only with timer run bit set; registers stay accessible.
// R14: Timer disabled removes the divide-by-64 accumulator clock.
// R15: Accumulator run bit clear stops accumulator; registers stay accessible.
// R16: Pin seven is accumulator input; selected edge counts an event.
// R17: Accumulator run is independent of timer run.
// R18: Pins map to channels one-to-one through a synchroniser.
// R19: Register accesses are single cycle, effective next clock edge.
module tpi_port_io (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic                        clk_en,
  // Register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [7:0]                       reg_rdata,
  // Device modes
  input  tpi_pkg::tpi_mode_type            mode,
  // Timer output compare
  input  wire logic [tpi_pkg::TPI_PINS-1:0] oc_enable,
  input  wire logic [tpi_pkg::TPI_PINS-1:0] oc_level,
  // Pins
  input  wire logic [tpi_pkg::TPI_PINS-1:0] pin_in,
  output logic [tpi_pkg::TPI_PINS-1:0]     pin_out,
  output logic [tpi_pkg::TPI_PINS-1:0]     pin_oe_n,
  // Timer side
  output tpi_pkg::tpi_chan_type            chan,
  output logic                             timer_run,
  output logic                             accum_run,
  output logic                             div64_tick,
  output logic                             accum_event,
  output logic                             accum_gate_tick,
  output logic                             accum_gate_end
);
  import tpi_pkg::*;

  logic [TPI_PINS-1:0] timer_pin_data;
  logic [TPI_PINS-1:0] timer_pin_direction;
  tpi_ctrl_type        control;
  logic [TPI_PINS-1:0] next_drive;
  logic [TPI_PINS-1:0] next_dir;
  logic [TPI_PINS-1:0] pin_readback;
  logic [7:0]          next_rdata;
  logic [7:0]          status;
  logic                accum_level;
  logic                accum_gate_open;

  tpi_sync u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .pin_in  (pin_in), // R4 R5
    .chan    (chan)
  );

  tpi_run_ctl u_run (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .mode       (mode),
    .ctrl       (control),
    .timer_run  (timer_run),
    .accum_run  (accum_run),
    .div64_tick (div64_tick)
  );

  // Data latch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_pin_data <= TPI_RST_DATA;
    end else if (clk_en && reg_wr && (reg_addr == TPI_ADDR_DATA)) begin
      timer_pin_data <= reg_wdata; // R2 R19
    end
  end

  // Direction register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_pin_direction <= TPI_RST_DIRECTION; // R6
    end else if (clk_en && reg_wr && (reg_addr == TPI_ADDR_DIRECTION)) begin
      timer_pin_direction <= reg_wdata; // R6 R19
    end
  end

  // Control register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      control <= tpi_ctrl_type'(TPI_RST_CONTROL[5:0]);
    end else if (clk_en && reg_wr && (reg_addr == TPI_ADDR_CONTROL)) begin
      control <= tpi_ctrl_type'(reg_wdata[5:0]);
    end
  end

  // Pin drive and direction
  always_comb begin
    for (int i = 0; i < TPI_PINS; i++) begin
      next_dir[i]   = timer_pin_direction[i] | oc_enable[i]; // R7 R8 R9
      next_drive[i] = oc_enable[i] ? oc_level[i] : timer_pin_data[i]; // R3 R2
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out  <= 8'h00;
      pin_oe_n <= 8'hFF;
    end else if (clk_en) begin
      pin_out  <= next_drive;
      pin_oe_n <= ~next_dir; // R6 R7
    end
  end

  // Readback: pin level for inputs, driver value for outputs
  always_comb begin
    for (int i = 0; i < TPI_PINS; i++) begin
      pin_readback[i] = pin_oe_n[i] ? chan.level[i] : pin_out[i]; // R1
    end
  end

  always_comb begin
    status                       = 8'h00;
    status[TPI_STS_TIMER_ACTIVE] = timer_run;
    status[TPI_STS_ACCUM_ACTIVE] = accum_run;
  end

  always_comb begin
    case (reg_addr)
      TPI_ADDR_DATA:      next_rdata = pin_readback; // R1
      TPI_ADDR_DIRECTION: next_rdata = timer_pin_direction; // R6
      TPI_ADDR_CONTROL:   next_rdata = {2'b00, control};
      TPI_ADDR_STATUS:    next_rdata = status;
      default:            next_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00; // R19
    end
  end

  // Pulse accumulator input on pin seven
  assign accum_level     = chan.level[TPI_ACCUM_PIN]; // R16 R18
  assign accum_gate_open = accum_level ^ control.accum_edge;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      accum_event     <= 1'b0;
      accum_gate_tick <= 1'b0;
      accum_gate_end  <= 1'b0;
    end else if (clk_en) begin
      accum_event <= accum_run && !control.accum_gated &&
                     (control.accum_edge ? chan.rise[TPI_ACCUM_PIN] : chan.fall[TPI_ACCUM_PIN]); // R16 R15
      accum_gate_tick <= accum_run && control.accum_gated && div64_tick && accum_gate_open; // R14 R15
      accum_gate_end  <= accum_run && control.accum_gated &&
                         (control.accum_edge ? chan.rise[TPI_ACCUM_PIN] : chan.fall[TPI_ACCUM_PIN]);
    end
  end

endmodule // tpi_port_io

// ---- tpi_run_ctl.sv ----
`timescale 1ns/100ps
module tpi_run_ctl (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rstn,
  input  wire logic           clk_en,
  // Controls
  input  tpi_pkg::tpi_mode_type mode,
  input  tpi_pkg::tpi_ctrl_type ctrl,
  // Run state
  output logic                timer_run,
  output logic                accum_run,
  output logic                div64_tick
);
  import tpi_pkg::*;

  logic [5:0] prescale;
  logic       next_timer_run;
  logic       next_accum_run;

  always_comb begin
    next_timer_run = ctrl.timer_run_bit; // R13
    if (mode.stop_mode) begin // R10
      next_timer_run = 1'b0;
    end
    if (mode.background_debug_state && ctrl.debug_freeze_bit) begin // R11
      next_timer_run = 1'b0;
    end
    if (mode.wait_mode && ctrl.wait_halt_bit) begin // R12
      next_timer_run = 1'b0;
    end
    next_accum_run = ctrl.accum_run_bit && !mode.stop_mode; // R15 R17
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_run <= 1'b0;
      accum_run <= 1'b0;
    end else if (clk_en) begin
      timer_run <= next_timer_run;
      accum_run <= next_accum_run;
    end
  end

  // Prescaler only advances while the timer runs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prescale   <= 6'h00;
      div64_tick <= 1'b0;
    end else if (clk_en) begin
      if (timer_run) begin // R14
        prescale   <= prescale + 6'h01;
        div64_tick <= (prescale == TPI_DIV64_LAST);
      end else begin
        div64_tick <= 1'b0;
      end
    end
  end

endmodule // tpi_run_ctl

// ---- tpi_sync.sv ----
`timescale 1ns/100ps
module tpi_sync (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic                    clk_en,
  // Pins
  input  wire logic [tpi_pkg::TPI_PINS-1:0] pin_in,
  // Synchronised view
  output tpi_pkg::tpi_chan_type        chan
);
  import tpi_pkg::*;

  logic [TPI_PINS-1:0] stage1;
  logic [TPI_PINS-1:0] stage2;
  logic [TPI_PINS-1:0] stage3;
  logic [TPI_PINS-1:0] level;
  logic [TPI_PINS-1:0] rise;
  logic [TPI_PINS-1:0] fall;

  genvar i;
  generate
    for (i = 0; i < TPI_PINS; i++) begin : g_bit
      // Three flops, level taken once stages two and three agree
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          level[i]  <= 1'b0;
          rise[i]   <= 1'b0;
          fall[i]   <= 1'b0;
        end else if (clk_en) begin
          stage1[i] <= pin_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin // R18
            level[i] <= stage3[i];
          end
          rise[i] <= (stage2[i] == stage3[i]) && stage3[i] && !level[i];
          fall[i] <= (stage2[i] == stage3[i]) && !stage3[i] && level[i];
        end
      end
    end
  endgenerate

  assign chan.level = level;
  assign chan.rise  = rise;
  assign chan.fall  = fall;

endmodule // tpi_sync
